// file: hw/eeprom_slave_end.sv
`timescale 1ns/10ps
module eeprom_slave_end
  import eeprom_pkg::*;
#(
  parameter logic [3:0] DEV_CODE   = 4'h5,  // arbitrary device-type code
  parameter int         ARRAY_BITS = 3,
  parameter int         WR_CYCLES  = WRITE_CYCLES
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // two-wire link
  i2c_link_if.dev   link,
  // address-select straps and protection
  input  wire logic selectPinBit0,
  input  wire logic selectPinBit1,
  input  wire logic selectPinBit2,
  input  wire logic writeProtect,
  // status
  output logic      writeBusy
);
  typedef enum logic [4:0] {
    D_IDLE = 5'b00001,
    D_ADDR = 5'b00010,
    D_WORD = 5'b00100,
    D_DATA = 5'b01000,
    D_READ = 5'b10000
  } dev_state_t;

  localparam logic [2:0]        ARR_MASK = 3'((1 << ARRAY_BITS) - 1);
  localparam logic [ADDR_W-1:0] PTR_MASK = {ARR_MASK, 8'hff};

  // ****************************************
  // storage
  // ****************************************
  logic [7:0] mem [MEM_BYTES];
  logic [7:0] pageBuf [PAGE_BYTES];

  // ****************************************
  // state
  // ****************************************
  logic [1:0]        sclSync_ff;
  logic [1:0]        sdaSync_ff;
  logic [1:0]        wpSync_ff;
  logic [2:0]        pinMeta_ff;
  logic [2:0]        pinSync_ff;
  logic              sclPrev_ff;
  logic              sdaPrev_ff;
  dev_state_t        state_ff;
  logic [3:0]        bitCnt_ff;
  logic [7:0]        shift_ff;
  logic [7:0]        tx_ff;
  logic              sdaLow_ff;
  logic [ADDR_W-1:0] ptr_ff;
  logic              dirRead_ff;
  logic              wpHit_ff;
  logic              mstAck_ff;
  logic [15:0]       pageValid_ff;
  logic              busy_ff;
  logic [19:0]       wrTimer_ff;
  logic [3:0]        commitIdx_ff;

  // ****************************************
  // decode
  // ****************************************
  logic              sclNow;
  logic              sdaNow;
  logic              sclRise;
  logic              sclFall;
  logic              startSeen;
  logic              stopSeen;
  logic [2:0]        extBits;
  logic              addrMatch;
  logic [ADDR_W-1:0] ptrNext;
  logic              active;
  logic              storeByte;

  assign sclNow    = sclSync_ff[1];
  assign sdaNow    = sdaSync_ff[1];
  assign sclRise   = sclNow & ~sclPrev_ff;
  assign sclFall   = ~sclNow & sclPrev_ff;
  // sda moving while scl stays high is framing, never data
  assign startSeen = sclNow & sclPrev_ff & sdaPrev_ff & ~sdaNow;
  assign stopSeen  = sclNow & sclPrev_ff & ~sdaPrev_ff & sdaNow;
  assign extBits   = shift_ff[3:1];
  // select bits compare against straps, array bits are don't-care here
  assign addrMatch = (shift_ff[7:4] == DEV_CODE) &&
                     (((extBits ^ pinSync_ff) & ~ARR_MASK) == 3'h0);
  // whole-array wrap, density shrinks the usable range
  assign ptrNext   = (ptr_ff + 11'h1) & PTR_MASK;
  assign active    = state_ff != D_IDLE;
  assign storeByte = active & sclFall & (bitCnt_ff == BIT_ACK) &
                     (state_ff == D_DATA) & ~wpHit_ff;

  // open drain: the output value is always low, only the enable moves
  assign link.sdaDevOut = 1'b0;
  assign link.sdaDevOe  = sdaLow_ff;
  assign writeBusy      = busy_ff;

  // ****************************************
  // synchronisers
  // ****************************************
  // bus idles high, so reset loads ones to avoid a false start
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sclSync_ff <= 2'h3;
      sdaSync_ff <= 2'h3;
      sclPrev_ff <= 1'b1;
      sdaPrev_ff <= 1'b1;
      wpSync_ff  <= 2'h0;
      pinMeta_ff <= 3'h0;
      pinSync_ff <= 3'h0;
    end else begin
      sclSync_ff <= {sclSync_ff[0], link.scl};
      sdaSync_ff <= {sdaSync_ff[0], link.sda};
      sclPrev_ff <= sclSync_ff[1];
      sdaPrev_ff <= sdaSync_ff[1];
      wpSync_ff  <= {wpSync_ff[0], writeProtect};
      pinMeta_ff <= {selectPinBit2, selectPinBit1, selectPinBit0};
      pinSync_ff <= pinMeta_ff;
    end
  end

  // ****************************************
  // array and page buffer
  // ****************************************
  // nonvolatile model: reset never touches it
  initial begin
    for (int i = 0; i < MEM_BYTES; i++) begin
      mem[i] = ERASED_BYTE;
    end
  end

  // commit walks the page one byte per clock while busy, the whole page every 16 clocks; repeats are harmless
  // plain always, since the erased start at time zero also writes the array
  always @(posedge core_clk) begin
    if (busy_ff && pageValid_ff[commitIdx_ff]) begin
      mem[{ptr_ff[ADDR_W-1:4], commitIdx_ff}] <= pageBuf[commitIdx_ff];
    end
  end

  always_ff @(posedge core_clk) begin
    if (storeByte) pageBuf[ptr_ff[3:0]] <= shift_ff;
  end

  // ****************************************
  // protocol engine
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff     <= D_IDLE;
      bitCnt_ff    <= 4'h0;
      shift_ff     <= 8'h00;
      tx_ff        <= 8'h00;
      sdaLow_ff    <= 1'b0;
      ptr_ff       <= '0;
      dirRead_ff   <= 1'b0;
      wpHit_ff     <= 1'b0;
      mstAck_ff    <= 1'b0;
      pageValid_ff <= 16'h0000;
      busy_ff      <= 1'b0;
      wrTimer_ff   <= 20'h00000;
      commitIdx_ff <= 4'h0;
    end else if (busy_ff) begin
      // deaf and released for the whole cycle, polling gets no ack
      state_ff     <= D_IDLE;
      sdaLow_ff    <= 1'b0;
      commitIdx_ff <= commitIdx_ff + 4'h1;
      if (wrTimer_ff == 20'h00000) begin
        busy_ff      <= 1'b0;
        pageValid_ff <= 16'h0000;
      end else begin
        wrTimer_ff <= wrTimer_ff - 20'h00001;
      end
    end else if (startSeen) begin
      // a restart abandons any unfinished page load
      state_ff     <= D_ADDR;
      bitCnt_ff    <= 4'h0;
      sdaLow_ff    <= 1'b0;
      pageValid_ff <= 16'h0000;
    end else if (stopSeen) begin
      state_ff  <= D_IDLE;
      sdaLow_ff <= 1'b0;
      if (state_ff == D_DATA && pageValid_ff != 16'h0000) begin
        busy_ff      <= 1'b1;
        wrTimer_ff   <= 20'(WR_CYCLES - 1);
        commitIdx_ff <= 4'h0;
      end
    end else if (active && sclRise) begin
      if (bitCnt_ff < BIT_ACK) shift_ff <= {shift_ff[6:0], sdaNow};
      if (bitCnt_ff == BIT_ACK) mstAck_ff <= ~sdaNow;
      bitCnt_ff <= bitCnt_ff + 4'h1;
    end else if (active && sclFall) begin
      if (bitCnt_ff == BIT_ACK) begin
        case (state_ff)
          D_ADDR: begin
            if (addrMatch) begin
              sdaLow_ff                <= 1'b1;
              dirRead_ff               <= shift_ff[0] == DIR_READ;
              ptr_ff[ADDR_W-1:8]       <= extBits & ARR_MASK;
            end else begin
              state_ff <= D_IDLE;
            end
          end
          D_WORD: begin
            sdaLow_ff   <= 1'b1;
            ptr_ff[7:0] <= shift_ff;
          end
          D_DATA: begin
            if (wpHit_ff) begin
              state_ff <= D_IDLE;
            end else begin
              sdaLow_ff                  <= 1'b1;
              pageValid_ff[ptr_ff[3:0]]  <= 1'b1;
              ptr_ff[3:0]                <= ptr_ff[3:0] + 4'h1;
            end
          end
          default: begin
            sdaLow_ff <= 1'b0;
          end
        endcase
      end else if (bitCnt_ff == BIT_DONE) begin
        bitCnt_ff <= 4'h0;
        sdaLow_ff <= 1'b0;
        case (state_ff)
          D_ADDR: begin
            if (dirRead_ff) begin
              state_ff  <= D_READ;
              tx_ff     <= mem[ptr_ff];
              sdaLow_ff <= ~mem[ptr_ff][7];
            end else begin
              state_ff <= D_WORD;
            end
          end
          D_WORD: begin
            state_ff <= D_DATA;
            wpHit_ff <= wpSync_ff[1];
          end
          D_READ: begin
            if (mstAck_ff) begin
              ptr_ff    <= ptrNext;
              tx_ff     <= mem[ptrNext];
              sdaLow_ff <= ~mem[ptrNext][7];
            end else begin
              state_ff <= D_IDLE;
            end
          end
          default: begin
            state_ff <= state_ff;
          end
        endcase
      end else if (state_ff == D_READ) begin
        tx_ff     <= {tx_ff[6:0], 1'b0};
        sdaLow_ff <= ~tx_ff[6];
      end
    end
  end
endmodule

// file: hw/eeprom_pkg.sv
package eeprom_pkg;

  // ****************************************
  // array geometry
  // ****************************************
  localparam int         ADDR_W      = 11;
  localparam int         MEM_BYTES   = 2048;
  localparam int         PAGE_BYTES  = 16;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // ****************************************
  // byte framing
  // ****************************************
  localparam logic [3:0] BIT_ACK  = 4'h8;  // rising edges seen when the ack clock starts
  localparam logic [3:0] BIT_DONE = 4'h9;  // rising edges seen when the ack clock ends
  localparam logic       DIR_READ = 1'b1;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ        = 100;
  localparam int WRITE_TIME_MS  = 5;
  localparam int WRITE_CYCLES   = WRITE_TIME_MS * 1000 * CLK_MHZ;
  localparam int SCL_QTR_NS     = 80;
  localparam int SCL_QTR_CYCLES = (SCL_QTR_NS * CLK_MHZ) / 1000;

endpackage

// file: hw/i2c_link_if.sv
`timescale 1ns/10ps
interface i2c_link_if;
  // open-drain drivers: an enable pulls the wire low
  logic sclOut;
  logic sclOe;
  logic sdaHostOut;
  logic sdaHostOe;
  logic sdaDevOut;
  logic sdaDevOe;
  // resolved wire levels, pull-ups assumed
  logic scl;
  logic sda;

  assign scl = ~(sclOe & ~sclOut);
  assign sda = ~((sdaHostOe & ~sdaHostOut) | (sdaDevOe & ~sdaDevOut));

  modport dev (input scl, input sda, output sdaDevOut, output sdaDevOe);
  modport host (input scl, input sda, output sclOut, output sclOe,
                output sdaHostOut, output sdaHostOe);
endinterface

// file: hw/sync_fifo.sv
`timescale 1ns/10ps
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // filling side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // draining side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wrPtr_ff;
  logic [AW-1:0]    rdPtr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  // handshakes straight from the occupancy count
  assign inReady  = count_ff != (AW+1)'(DEPTH);
  assign outValid = count_ff != '0;
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;
  assign outData  = store[rdPtr_ff];

  // pointers wrap on their own only for power-of-two depth
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) wrPtr_ff <= (wrPtr_ff == AW'(DEPTH-1)) ? '0 : wrPtr_ff + 1'b1;
      if (pop) rdPtr_ff <= (rdPtr_ff == AW'(DEPTH-1)) ? '0 : rdPtr_ff + 1'b1;
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // storage needs no reset
  always_ff @(posedge core_clk) begin
    if (push) store[wrPtr_ff] <= inData;
  end
endmodule

// file: hw/i2c_master_end.sv
`timescale 1ns/10ps
module i2c_master_end
  import eeprom_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // two-wire link
  i2c_link_if.host        link,
  // byte commands
  input  wire logic       cmdValid,
  output logic            cmdReady,
  input  wire logic       cmdStart,
  input  wire logic       cmdStop,
  input  wire logic       cmdRead,
  input  wire logic       cmdNack,
  input  wire logic [7:0] cmdData,
  // results
  output logic            ackSeen,
  output logic            hostIdle,
  output logic            rxValid,
  input  wire logic       rxReady,
  output logic      [7:0] rxData
);
  typedef enum logic [3:0] {
    H_IDLE  = 4'b0001,
    H_START = 4'b0010,
    H_BIT   = 4'b0100,
    H_STOP  = 4'b1000
  } host_state_t;

  host_state_t state_ff;
  logic [7:0]  qCnt_ff;
  logic [1:0]  phase_ff;
  logic [3:0]  bitCnt_ff;
  logic [8:0]  txSh_ff;
  logic [8:0]  rxSh_ff;
  logic        sclHigh_ff;
  logic        sdaRel_ff;
  logic        stopPend_ff;
  logic        readPend_ff;
  logic        ack_ff;
  logic [1:0]  sdaSync_ff;
  logic        tick;
  logic        accept;
  logic        byteEnd;
  logic        fifoInReady;
  logic        push;

  // a read is taken only when the fifo has room for its byte
  assign cmdReady = (state_ff == H_IDLE) & (~cmdRead | fifoInReady);
  assign accept   = cmdValid & cmdReady;
  assign tick     = qCnt_ff == 8'h00;
  assign byteEnd  = tick & (state_ff == H_BIT) & (phase_ff == 2'h3) & (bitCnt_ff == BIT_ACK);
  assign push     = byteEnd & readPend_ff;
  assign hostIdle = state_ff == H_IDLE;
  assign ackSeen  = ack_ff;

  assign link.sclOut     = 1'b0;
  assign link.sclOe      = ~sclHigh_ff;
  assign link.sdaHostOut = 1'b0;
  assign link.sdaHostOe  = ~sdaRel_ff;

  // ****************************************
  // received bytes
  // ****************************************
  sync_fifo #(.WIDTH(8), .DEPTH(8)) rxFifo (
    .core_clk (core_clk),
    .rst      (rst),
    .inValid  (push),
    .inReady  (fifoInReady),
    .inData   (rxSh_ff[8:1]),
    .outValid (rxValid),
    .outReady (rxReady),
    .outData  (rxData)
  );

  // ****************************************
  // bit engine, four quarter phases per bit
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff    <= H_IDLE;
      qCnt_ff     <= 8'h00;
      phase_ff    <= 2'h0;
      bitCnt_ff   <= 4'h0;
      txSh_ff     <= 9'h1ff;
      rxSh_ff     <= 9'h000;
      sclHigh_ff  <= 1'b1;
      sdaRel_ff   <= 1'b1;
      stopPend_ff <= 1'b0;
      readPend_ff <= 1'b0;
      ack_ff      <= 1'b0;
      sdaSync_ff  <= 2'h3;
    end else begin
      sdaSync_ff <= {sdaSync_ff[0], link.sda};
      qCnt_ff    <= tick ? 8'(SCL_QTR_CYCLES - 1) : qCnt_ff - 8'h01;
      if (accept) begin
        // read ack bit: drive low to continue, release to end
        txSh_ff     <= cmdRead ? {8'hff, cmdNack} : {cmdData, 1'b1};
        stopPend_ff <= cmdStop;
        readPend_ff <= cmdRead;
        bitCnt_ff   <= 4'h0;
        phase_ff    <= 2'h0;
        state_ff    <= cmdStart ? H_START : H_BIT;
      end else if (tick && state_ff != H_IDLE) begin
        phase_ff <= phase_ff + 2'h1;
        case (state_ff)
          H_START: begin
            if (phase_ff == 2'h0) sdaRel_ff <= 1'b1;
            if (phase_ff == 2'h1) sclHigh_ff <= 1'b1;
            if (phase_ff == 2'h2) sdaRel_ff <= 1'b0;
            if (phase_ff == 2'h3) begin
              sclHigh_ff <= 1'b0;
              state_ff   <= H_BIT;
            end
          end
          H_BIT: begin
            if (phase_ff == 2'h0) begin
              sdaRel_ff <= txSh_ff[8];
              txSh_ff   <= {txSh_ff[7:0], 1'b1};
            end
            if (phase_ff == 2'h1) sclHigh_ff <= 1'b1;
            if (phase_ff == 2'h2) rxSh_ff <= {rxSh_ff[7:0], sdaSync_ff[1]};
            if (phase_ff == 2'h3) begin
              sclHigh_ff <= 1'b0;
              bitCnt_ff  <= bitCnt_ff + 4'h1;
              if (bitCnt_ff == BIT_ACK) begin
                ack_ff   <= ~rxSh_ff[0];
                state_ff <= stopPend_ff ? H_STOP : H_IDLE;
              end
            end
          end
          default: begin
            if (phase_ff == 2'h0) sdaRel_ff <= 1'b0;
            if (phase_ff == 2'h1) sclHigh_ff <= 1'b1;
            if (phase_ff == 2'h2) sdaRel_ff <= 1'b1;
            if (phase_ff == 2'h3) state_ff <= H_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// file: sim/eeprom_link_assertions.sv
`timescale 1ns/10ps
module eeprom_link_assertions #(
  parameter int WR_CYCLES = 1000
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // link wires and drivers
  input wire logic scl,
  input wire logic sda,
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic sdaHostOut,
  input wire logic sdaHostOe,
  input wire logic sdaDevOut,
  input wire logic sdaDevOe,
  // status
  input wire logic writeBusy
);
  // ****************************************
  // helper state
  // ****************************************
  int   busyCnt_ff;
  logic started_ff;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // length of the current busy stretch
  always_ff @(posedge core_clk) begin
    if (rst) busyCnt_ff <= 0;
    else busyCnt_ff <= writeBusy ? busyCnt_ff + 1 : 0;
  end

  // seen on the wires, so it leads the device's own detector
  always_ff @(posedge core_clk) begin
    if (rst) started_ff <= 1'b0;
    else if (scl && $fell(sda)) started_ff <= 1'b1;
  end

  // ****************************************
  // checks
  // ****************************************
  never_drive_high_a: assert property (sdaDevOe |-> !sdaDevOut)
    else $error("device drove the data line high");
  change_on_low_a: assert property ($changed(sdaDevOe) |-> !scl)
    else $error("device data changed while clock high");
  setup_before_rise_a: assert property ($rose(sdaDevOe) |-> !scl [*5])
    else $error("device data launched too close to clock rise");
  clock_high_len_a: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase shorter than a quarter");
  // both may pull low while scl is low; a bit on the wire has one sender
  no_contention_a: assert property (scl && sdaDevOe |-> !sdaHostOe)
    else $error("both ends drive the data line while clock high");
  busy_silent_a: assert property (writeBusy |-> !sdaDevOe)
    else $error("device answers while writing");
  busy_length_a: assert property ($fell(writeBusy) |->
      busyCnt_ff >= WR_CYCLES - 1 && busyCnt_ff <= WR_CYCLES + 1)
    else $error("write cycle length wrong");
  quiet_until_start_a: assert property (!started_ff |-> !sdaDevOe)
    else $error("device drove before any start");
endmodule

// file: sim/i2c_serial_eeprom_slave_tb.sv
`timescale 1ns/10ps
module i2c_serial_eeprom_slave_tb
  import eeprom_pkg::*;
;
  localparam int         WR  = 1000;
  localparam logic [7:0] AW  = 8'h5a;  // code 5, pins 2 and 1 match, pointer bit 8 set
  localparam logic [7:0] AR  = 8'h5b;
  localparam logic [7:0] AW0 = 8'h58;
  localparam logic [7:0] AR0 = 8'h59;

  logic       core_clk;
  logic       rst;
  logic       cmdValid;
  logic       cmdStart;
  logic       cmdStop;
  logic       cmdRead;
  logic       cmdNack;
  logic [7:0] cmdData;
  logic       rxReady;
  logic       writeProtect;
  logic       cmdReady;
  logic       ackSeen;
  logic       hostIdle;
  logic       rxValid;
  logic [7:0] rxData;
  logic       writeBusy;
  logic [2:0] selPins;
  int         fail_count;
  int         compares;
  int         cycles;
  int         n;

  i2c_link_if link();
  i2c_master_end u_i2c_master_end (.core_clk, .rst, .link(link), .cmdValid, .cmdReady,
    .cmdStart, .cmdStop, .cmdRead, .cmdNack, .cmdData, .ackSeen, .hostIdle, .rxValid,
    .rxReady, .rxData);
  eeprom_slave_end #(.ARRAY_BITS(1), .WR_CYCLES(WR)) u_eeprom_slave_end (.core_clk, .rst,
    .link(link), .selectPinBit0(selPins[0]), .selectPinBit1(selPins[1]),
    .selectPinBit2(selPins[2]), .writeProtect, .writeBusy);
  eeprom_link_assertions #(.WR_CYCLES(WR)) u_eeprom_link_assertions (.core_clk, .rst,
    .scl(link.scl), .sda(link.sda), .sclOut(link.sclOut), .sclOe(link.sclOe),
    .sdaHostOut(link.sdaHostOut), .sdaHostOe(link.sdaHostOe), .sdaDevOut(link.sdaDevOut),
    .sdaDevOe(link.sdaDevOe), .writeBusy);

  // ****************************************
  // clock, timeout and verdict
  // ****************************************
  always #5 core_clk = ~core_clk;

  // roughly seventy-five bytes plus write cycles; the ceiling leaves ample slack
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 90000) begin
      fail_count++;
      $display("[FAIL] %0t run timed out", $time);
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("mismatches %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ****************************************
  // access tasks
  // ****************************************
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // one byte command; held until taken, then wait for the engine to go idle
  task automatic xfer(input logic s, p, r, k, input logic [7:0] d);
    int w;
    @(posedge core_clk);
    #1;
    {cmdStart, cmdStop, cmdRead, cmdNack, cmdData} = {s, p, r, k, d};
    cmdValid = 1'b1;
    w = 0;
    while (cmdReady !== 1'b1 && w < 3000) begin
      @(posedge core_clk);
      #1;
      w++;
    end
    if (w == 3000) begin
      fail_count++;
      $display("[FAIL] %0t command never taken", $time);
    end
    @(posedge core_clk);
    #1;
    cmdValid = 1'b0;
    do begin
      @(posedge core_clk);
      #1;
    end while (hostIdle !== 1'b1);
  endtask

  task automatic wr(input logic s, p, input logic [7:0] d, input logic ack);
    xfer(s, p, 1'b0, 1'b0, d);
    check({7'h0, ackSeen}, {7'h0, ack}, "acknowledge");
  endtask

  task automatic pop(input logic [7:0] exp);
    int w;
    w = 0;
    while (rxValid !== 1'b1 && w < 100) begin
      @(posedge core_clk);
      #1;
      w++;
    end
    check({7'h0, rxValid}, 8'h01, "read data present");
    check(rxData, exp, "read data");
    rxReady = 1'b1;
    @(posedge core_clk);
    #1;
    rxReady = 1'b0;
    // one idle edge so a following pop never raises ready in the same step
    @(posedge core_clk);
    #1;
  endtask

  task automatic rd(input logic k, p, input logic [7:0] exp);
    xfer(1'b0, p, 1'b1, k, 8'h00);
    pop(exp);
  endtask

  task automatic seek(input logic [7:0] a, input logic [7:0] word);
    wr(1'b1, 1'b0, a, 1'b1);
    wr(1'b0, 1'b0, word, 1'b1);
  endtask

  // start, write address, stop until the device answers
  task automatic poll(output int cnt);
    cnt = 0;
    do begin
      xfer(1'b1, 1'b1, 1'b0, 1'b0, AW);
      cnt++;
    end while (ackSeen !== 1'b1 && cnt < 40);
    check({7'h0, ackSeen}, 8'h01, "poll answered");
  endtask

  // eighteen bytes from offset 14: the last two land on 14 and 15 again
  function automatic logic [7:0] pageVal(input int k);
    return 8'h40 + 8'((k + 2) % 16) + ((k >= 14) ? 8'h10 : 8'h00);
  endfunction

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    {core_clk, cmdValid, cmdStart, cmdStop, cmdRead, cmdNack, rxReady, writeProtect} = '0;
    cmdData = 8'h00;
    selPins = 3'h5;
    rst = 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge core_clk);
    // selective read of an untouched location
    seek(AW, 8'h23);
    wr(1'b1, 1'b0, AR, 1'b1);
    rd(1'b1, 1'b1, ERASED_BYTE);
    check({6'h0, link.scl, link.sda}, 8'h03, "bus idle after stop");
    // foreign select pins and foreign type code stay unanswered
    wr(1'b1, 1'b1, 8'h52, 1'b0);
    wr(1'b1, 1'b1, 8'h7a, 1'b0);
    // straps moved away from the address the master keeps sending
    selPins = 3'h1;
    wr(1'b1, 1'b1, AW, 1'b0);
    selPins = 3'h5;
    // page write overrunning the page, then ack polling
    seek(AW, 8'hfe);
    for (int i = 0; i < 18; i++) wr(1'b0, i == 17, 8'(8'h40 + i), 1'b1);
    check({7'h0, writeBusy}, 8'h01, "busy after stop");
    poll(n);
    check(8'(n > 1), 8'h01, "early polls refused");
    check({7'h0, writeBusy}, 8'h00, "idle after write");
    // sequential read across the page end and the array end
    seek(AW, 8'hfe);
    wr(1'b1, 1'b0, AR, 1'b1);
    rd(1'b0, 1'b0, pageVal(14));
    rd(1'b0, 1'b0, pageVal(15));
    rd(1'b0, 1'b0, ERASED_BYTE);
    rd(1'b1, 1'b1, ERASED_BYTE);
    // immediate read keeps the pointer of an unacked byte
    seek(AW, 8'hf0);
    wr(1'b1, 1'b0, AR, 1'b1);
    rd(1'b1, 1'b1, pageVal(0));
    wr(1'b1, 1'b0, AR, 1'b1);
    rd(1'b1, 1'b1, pageVal(0));
    // fill the read buffer until it refuses, then drain it
    wr(1'b1, 1'b0, AR, 1'b1);
    for (int k = 0; k < 8; k++) xfer(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
    check({7'h0, cmdReady}, 8'h00, "full buffer refuses reads");
    for (int k = 0; k < 8; k++) pop(pageVal(k));
    check({7'h0, rxValid}, 8'h00, "buffer empty");
    rd(1'b1, 1'b1, pageVal(8));
    // protected write is refused and leaves the array alone
    writeProtect = 1'b1;
    seek(AW0, 8'h00);
    wr(1'b0, 1'b1, 8'h3c, 1'b0);
    check({7'h0, writeBusy}, 8'h00, "no write cycle");
    writeProtect = 1'b0;
    seek(AW0, 8'h00);
    wr(1'b1, 1'b0, AR0, 1'b1);
    rd(1'b1, 1'b1, ERASED_BYTE);
    // plain byte write and read back
    seek(AW0, 8'h00);
    wr(1'b0, 1'b1, 8'h3c, 1'b1);
    poll(n);
    seek(AW0, 8'h00);
    wr(1'b1, 1'b0, AR0, 1'b1);
    rd(1'b1, 1'b1, 8'h3c);
    // reset in the middle of a write cycle ends it and leaves the device ready
    seek(AW0, 8'h01);
    wr(1'b0, 1'b1, 8'h77, 1'b1);
    rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    rst = 1'b0;
    check({7'h0, writeBusy}, 8'h00, "reset ends write cycle");
    wr(1'b1, 1'b1, AW0, 1'b1);
    report_and_stop();
  end
endmodule
